/* tdc_pkg.sv */
/*
  Constants, types and register map of the transmit descriptor control decoder.
  Assumes one AHB-Lite slave port with 32-bit data; every register is one aligned word.
*/
// Summary of operation
// - Completion interrupt only on frame-closing descriptor
// - Start flag opens a frame
// - End flag closes a frame
// - IP sum request when global bit clear
// - Insertion assumes fixed 20-byte IP header
// - TCP sum request when global bit clear
// - UDP sum request when global bit clear
// - End-of-ring wraps index to list base
// - Four-bit destination port map field
// - Low bit port 1, next port 2
// - All ones broadcasts to all ports
// - All zeros uses internal address lookup
// - Port map taken from closing descriptor only
// - Upper two map bits reserved, ignored
// - Read exactly byte count bytes
// - Zero byte count skips the buffer
// - Clear ownership when buffer emptied
// - Buffer address may have any alignment
package tdc_pkg;
  // Byte offsets of the registers
  localparam logic [7:0] TDC_CTL_OFS = 8'h00;
  localparam logic [7:0] TDC_CMD_OFS = 8'h04;
  localparam logic [7:0] TDC_MODE_OFS = 8'h08;
  localparam logic [7:0] TDC_STAT_OFS = 8'h0c;
  localparam logic [7:0] TDC_FRAME_OFS = 8'h10;
  localparam logic [7:0] TDC_PTR_OFS = 8'h14;
  // Field positions in the control word
  localparam int TDC_IRQ_BIT = 31;
  localparam int TDC_START_BIT = 30;
  localparam int TDC_END_BIT = 29;
  localparam int TDC_IP_BIT = 28;
  localparam int TDC_TCP_BIT = 27;
  localparam int TDC_UDP_BIT = 26;
  localparam int TDC_EOR_BIT = 25;
  localparam int TDC_PM_LO = 20;
  localparam int TDC_PM_USED_HI = 21;
  localparam int TDC_BC_HI = 10;
  // Mode and command bits
  localparam int TDC_MODE_IP = 0;
  localparam int TDC_MODE_TCP = 1;
  localparam int TDC_MODE_UDP = 2;
  localparam int TDC_MODE_FCS = 3;
  localparam int TDC_CMD_GO = 0;
  // Status bits
  localparam int TDC_ST_OWN = 0;
  localparam int TDC_ST_BUSY = 1;
  localparam int TDC_ST_INFRAME = 2;
  localparam int TDC_ST_SEQERR = 3;
  localparam int TDC_ST_CFGWARN = 4;
  // Reset values and fixed figures
  localparam logic [31:0] TDC_CTL_RST = 32'h0000_0000;
  localparam logic [3:0] TDC_MODE_RST = 4'h0;
  localparam logic [31:0] TDC_PTR_RST = 32'h0000_0000;
  localparam logic [4:0] TDC_IP_HDR_BYTES = 5'h14;
  localparam logic [1:0] TDC_PM_ALL = 2'h3;

  typedef enum logic [1:0] {
    TDC_IDLE = 2'b00,
    TDC_READ = 2'b01,
    TDC_DONE = 2'b10
  } tdc_state_e;

  // Per-frame result handed to the frame engine
  typedef struct packed {
    logic irq;
    logic ip;
    logic tcp;
    logic udp;
    logic lookup;
    logic bcast;
    logic [1:0] ports;
  } tdc_frame_s;
endpackage

/* tdc_decode.sv */
/*
  Transmit descriptor control word decoder and buffer sequencer, with its AHB-Lite registers.
  Assumes a single-master AHB-Lite bus on hclk; the frame engine samples the outputs on hclk.
*/
`timescale 1ns/1ns
module tdc_decode
  import tdc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Buffer fetch towards memory
  output logic dma_rd_active,
  output logic [31:0] dma_addr,
  // Frame results towards the frame engine
  output tdc_frame_s frame_info,
  output logic frame_done,
  output logic tx_irq,
  output logic ring_wrap,
  output logic [7:0] desc_index
);
  logic [31:0] ctl_reg;
  logic [3:0] mode_reg;
  logic [31:0] ptr_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  tdc_state_e state_reg;
  logic [10:0] left_reg;
  logic [15:0] len_reg;
  logic own_reg;
  logic in_frame_reg;
  logic seq_err_reg;
  logic cfg_warn_reg;
  logic [31:0] rdata_next;
  logic go;
  logic sel;
  logic stat_wr;
  logic any_sum;

  // Per-packet request counts only while the global bit is clear; either enables insertion
  function automatic logic eff_sum(input logic glob, input logic req);
    eff_sum = glob | (req & ~glob);
  endfunction

  // Register read mux, used only by the bus read path
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      TDC_CTL_OFS: rd_mux = ctl_reg;
      TDC_MODE_OFS: rd_mux = {28'h0000000, mode_reg};
      TDC_STAT_OFS: rd_mux = {len_reg, desc_index, 3'h0, cfg_warn_reg, seq_err_reg,
                              in_frame_reg, (state_reg != TDC_IDLE), own_reg};
      TDC_FRAME_OFS: rd_mux = {19'h00000, TDC_IP_HDR_BYTES, frame_info};
      TDC_PTR_OFS: rd_mux = ptr_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  assign sel = hsel & htrans[1] & hready;
  // The mux reads registers that are not its argument; a process follows them, a plain assign would go stale
  always_comb rdata_next = rd_mux(haddr);
  assign go = wr_pend_reg & (wr_addr_reg == TDC_CMD_OFS) & hwdata[TDC_CMD_GO] & (state_reg == TDC_IDLE);
  assign stat_wr = wr_pend_reg & (wr_addr_reg == TDC_STAT_OFS);
  assign any_sum = ctl_reg[TDC_IP_BIT] | ctl_reg[TDC_TCP_BIT] | ctl_reg[TDC_UDP_BIT];

  // Zero-wait slave: always ready, always OKAY; read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= sel & hwrite;
      if (sel) begin
        wr_addr_reg <= haddr;
      end
      if (sel && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  // Software-written registers; the control word is frozen while a buffer is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= TDC_CTL_RST;
      mode_reg <= TDC_MODE_RST;
      ptr_reg <= TDC_PTR_RST;
    end else if (wr_pend_reg && state_reg == TDC_IDLE) begin
      case (wr_addr_reg)
        TDC_CTL_OFS: ctl_reg <= hwdata;
        TDC_MODE_OFS: mode_reg <= hwdata[3:0];
        TDC_PTR_OFS: ptr_reg <= hwdata; // Any byte alignment taken as is
        default: ctl_reg <= ctl_reg;
      endcase
    end
  end

  // Buffer sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TDC_IDLE;
      left_reg <= 11'h000;
      dma_rd_active <= 1'b0;
      dma_addr <= 32'h0000_0000;
    end else begin
      case (state_reg)
        TDC_IDLE: begin
          if (go) begin
            if (ctl_reg[TDC_BC_HI:0] == 11'h000) begin
              state_reg <= TDC_DONE; // Empty buffer skipped
            end else begin
              state_reg <= TDC_READ;
              left_reg <= ctl_reg[TDC_BC_HI:0];
              dma_rd_active <= 1'b1;
              dma_addr <= ptr_reg;
            end
          end
        end
        TDC_READ: begin
          // One byte a cycle; stop after exactly the counted bytes
          left_reg <= left_reg - 11'h001;
          if (left_reg == 11'h001) begin
            state_reg <= TDC_DONE;
            dma_rd_active <= 1'b0;
          end else begin
            dma_addr <= dma_addr + 32'h0000_0001;
          end
        end
        TDC_DONE: state_reg <= TDC_IDLE;
        default: state_reg <= TDC_IDLE;
      endcase
    end
  end

  // Ownership and ring position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_reg <= 1'b0;
      desc_index <= 8'h00;
      ring_wrap <= 1'b0;
    end else begin
      ring_wrap <= 1'b0;
      if (go) begin
        own_reg <= 1'b1;
      end else if (state_reg == TDC_DONE) begin
        own_reg <= 1'b0; // Returned to the host once the buffer is emptied
        if (ctl_reg[TDC_EOR_BIT]) begin
          desc_index <= 8'h00; // Next fetch from the list base
          ring_wrap <= 1'b1;
        end else begin
          desc_index <= desc_index + 8'h01;
        end
      end
    end
  end

  // Frame assembly: length accumulates across segments from start to end flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_frame_reg <= 1'b0;
      len_reg <= 16'h0000;
      seq_err_reg <= 1'b0;
    end else begin
      if (go && ctl_reg[TDC_BC_HI:0] != 11'h000) begin
        if (ctl_reg[TDC_START_BIT]) begin
          in_frame_reg <= 1'b1;
          len_reg <= 16'h0000;
        end
      end else if (state_reg == TDC_READ) begin
        len_reg <= len_reg + 16'h0001; // Buffers concatenated in order
      end else if (state_reg == TDC_DONE && ctl_reg[TDC_END_BIT] && ctl_reg[TDC_BC_HI:0] != 11'h000) begin
        in_frame_reg <= 1'b0;
      end
      // Segment without an open frame, or a new start inside one; set wins over clear
      if (go && ctl_reg[TDC_BC_HI:0] != 11'h000 && (ctl_reg[TDC_START_BIT] == in_frame_reg)) begin
        seq_err_reg <= 1'b1;
      end else if (stat_wr && hwdata[TDC_ST_SEQERR]) begin
        seq_err_reg <= 1'b0;
      end
    end
  end

  // Checksum request without FCS append is flagged for the driver; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_warn_reg <= 1'b0;
    end else if (go && any_sum && !mode_reg[TDC_MODE_FCS]) begin
      cfg_warn_reg <= 1'b1;
    end else if (stat_wr && hwdata[TDC_ST_CFGWARN]) begin
      cfg_warn_reg <= 1'b0;
    end
  end

  // Frame results latched only from the closing descriptor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_info <= '0;
      frame_done <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      tx_irq <= 1'b0;
      if (state_reg == TDC_DONE && ctl_reg[TDC_END_BIT] && ctl_reg[TDC_BC_HI:0] != 11'h000) begin
        frame_done <= 1'b1;
        tx_irq <= ctl_reg[TDC_IRQ_BIT]; // End flag already required
        frame_info.irq <= ctl_reg[TDC_IRQ_BIT];
        // Insertion assumes a 20-byte IP header
        frame_info.ip <= eff_sum(mode_reg[TDC_MODE_IP], ctl_reg[TDC_IP_BIT]);
        frame_info.tcp <= eff_sum(mode_reg[TDC_MODE_TCP], ctl_reg[TDC_TCP_BIT]);
        frame_info.udp <= eff_sum(mode_reg[TDC_MODE_UDP], ctl_reg[TDC_UDP_BIT]);
        // Bit 0 is port 1, bit 1 port 2; upper map bits ignored
        frame_info.ports <= ctl_reg[TDC_PM_USED_HI:TDC_PM_LO];
        frame_info.bcast <= (ctl_reg[TDC_PM_USED_HI:TDC_PM_LO] == TDC_PM_ALL);
        frame_info.lookup <= (ctl_reg[TDC_PM_USED_HI:TDC_PM_LO] == 2'h0);
      end
    end
  end

  // Helper: bytes read for the current descriptor
  logic [10:0] rd_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_reg <= 11'h000;
    end else if (go) begin
      rd_cnt_reg <= 11'h000;
    end else if (dma_rd_active) begin
      rd_cnt_reg <= rd_cnt_reg + 11'h001;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  skip_empty_a: assert property (go && ctl_reg[10:0] == 11'h000 |=> state_reg == TDC_DONE ##1 !dma_rd_active)
    else $error("empty buffer was not skipped");
  read_exact_a: assert property ($fell(dma_rd_active) |-> rd_cnt_reg == ctl_reg[10:0])
    else $error("byte count mismatch");
  own_return_a: assert property (state_reg == TDC_DONE |=> !own_reg && state_reg == TDC_IDLE)
    else $error("ownership not returned");
  ring_wrap_a: assert property (state_reg == TDC_DONE && ctl_reg[25] |=> desc_index == 8'h00 && ring_wrap)
    else $error("ring did not wrap");
  irq_end_a: assert property (tx_irq |-> frame_done && $past(ctl_reg[29]) && $past(ctl_reg[31]))
    else $error("interrupt without closing descriptor");
  port_map_a: assert property (frame_done |-> frame_info.ports == ctl_reg[21:20]
                               && frame_info.lookup == (ctl_reg[21:20] == 2'h0))
    else $error("port map decode wrong");
  sum_gate_a: assert property (frame_done |-> frame_info.ip == (mode_reg[0] | ctl_reg[28])
                               && frame_info.udp == (mode_reg[2] | ctl_reg[26]))
    else $error("checksum enable wrong");
  addr_step_a: assert property (dma_rd_active && $past(dma_rd_active) && state_reg == TDC_READ
                                |-> dma_addr == $past(dma_addr) + 32'h1)
    else $error("buffer address did not step");

  // Zero-wait slave never stalls and never answers with an error
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not OKAY");

  // Control and pointer writes that arrive while a buffer is in flight are dropped
  frozen_regs_a: assert property (wr_pend_reg && state_reg != TDC_IDLE |=> $stable(ctl_reg) && $stable(ptr_reg))
    else $error("register changed while busy");

  // A start-flagged segment opens the frame and restarts the length
  frame_open_a: assert property (go && ctl_reg[TDC_BC_HI:0] != 11'h000 && ctl_reg[TDC_START_BIT]
                                 |=> in_frame_reg && len_reg == 16'h0000)
    else $error("frame not opened");

  // An end-flagged segment closes the frame and reports it
  frame_close_a: assert property (state_reg == TDC_DONE && ctl_reg[TDC_END_BIT] && ctl_reg[TDC_BC_HI:0] != 11'h000
                                  |=> frame_done && !in_frame_reg)
    else $error("frame not closed");

  // A segment without the end flag reports nothing
  no_close_a: assert property (state_reg == TDC_DONE && !ctl_reg[TDC_END_BIT] |=> !frame_done && !tx_irq)
    else $error("frame reported from a middle segment");

  // In the frame_done cycle the interrupt pulse matches the latched completion request
  irq_match_a: assert property (frame_done |-> tx_irq == frame_info.irq)
    else $error("interrupt and frame result disagree");

  // Every byte read while a frame is open adds to its length
  len_count_a: assert property (state_reg == TDC_READ |=> len_reg == $past(len_reg) + 16'h0001)
    else $error("frame length did not count");

  // Out-of-order framing raises the sequence flag
  seq_flag_a: assert property (go && ctl_reg[TDC_BC_HI:0] != 11'h000 && ctl_reg[TDC_START_BIT] == in_frame_reg
                               |=> seq_err_reg)
    else $error("sequence error not flagged");

  // A sum request without FCS append raises the configuration flag
  cfg_flag_a: assert property (go && any_sum && !mode_reg[TDC_MODE_FCS] |=> cfg_warn_reg)
    else $error("configuration warning not flagged");

  // Broadcast only when both used map bits are set
  bcast_map_a: assert property (frame_done |-> frame_info.bcast == (frame_info.ports == 2'h3))
    else $error("broadcast decode wrong");

  // TCP insertion follows the global bit or the per-packet request
  tcp_gate_a: assert property (frame_done |-> frame_info.tcp == (mode_reg[TDC_MODE_TCP] | ctl_reg[TDC_TCP_BIT]))
    else $error("tcp checksum enable wrong");

  // Without end-of-ring the index moves on by one
  index_step_a: assert property (state_reg == TDC_DONE && !ctl_reg[TDC_EOR_BIT]
                                 |=> desc_index == $past(desc_index) + 8'h01 && !ring_wrap)
    else $error("descriptor index did not step");

  // An empty buffer produces no fetch and no frame report
  skip_quiet_a: assert property (go && ctl_reg[TDC_BC_HI:0] == 11'h000 |=> !dma_rd_active ##1 !frame_done)
    else $error("empty buffer produced activity");

  // Handing a descriptor over gives it to the block
  own_taken_a: assert property (go |=> own_reg)
    else $error("ownership not taken");

  // Byte fetch only happens in the read state
  fetch_state_a: assert property (state_reg != TDC_READ |-> !dma_rd_active)
    else $error("fetch outside the read state");

  frame_irq_c: cover property (frame_done && tx_irq);
  skip_c: cover property (go && ctl_reg[10:0] == 11'h000);
  wrap_c: cover property (ring_wrap);
  bcast_c: cover property (frame_done && frame_info.bcast);
  flags_c: cover property (seq_err_reg && cfg_warn_reg);
endmodule // tdc_decode

/* tdc_host_model.sv */
/*
  Host driver model: issues single-word AHB-Lite transfers to the decoder.
  Assumes hready is the slave's hreadyout and the clock is hclk.
*/
`timescale 1ns/1ns
module tdc_host_model
  import tdc_pkg::*;
(
  // Clock and bus answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; address phase held until hready, then data phase
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Stale data would hide a late sample, so drive its inverse
    hwdata <= ~d;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask

  // FCS append is turned on with every mode setting, with or without a sum request
  task set_mode(input logic [2:0] sums);
    wr(TDC_MODE_OFS, {28'h0, 1'b1, sums});
  endtask
endmodule // tdc_host_model

/* tdc_decode_tb_top.sv */
/*
  Self-checking testbench of the descriptor control decoder.
  Assumes the host model drives the bus; one descriptor is handed over at a time.
*/
`timescale 1ns/1ns
module tdc_decode_tb_top
  import tdc_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, dma_rd_active, frame_done, tx_irq, ring_wrap;
  logic [7:0] haddr, desc_index;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, dma_addr, exp_addr, rv;
  tdc_frame_s frame_info;
  int err_count = 0;
  int compares = 0;
  int n_rd, n_done, n_irq, n_wrap;

  initial forever #10 hclk = ~hclk;

  tdc_decode i_dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dma_rd_active(dma_rd_active), .dma_addr(dma_addr),
    .frame_info(frame_info), .frame_done(frame_done), .tx_irq(tx_irq), .ring_wrap(ring_wrap),
    .desc_index(desc_index));
  tdc_host_model i_host(.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Byte fetch must walk up from the buffer pointer one byte a cycle
  always @(posedge hclk) begin
    if (dma_rd_active === 1'b1) begin
      chk(dma_addr, exp_addr, "fetch address");
      exp_addr = exp_addr + 1;
      n_rd++;
    end
    if (frame_done === 1'b1) n_done++;
    if (tx_irq === 1'b1) n_irq++;
    if (ring_wrap === 1'b1) n_wrap++;
  end

  // Hand one descriptor over and poll until the block is idle again
  task run(input logic [31:0] ctl, input logic [31:0] ptr);
    int k;
    n_rd = 0;
    n_done = 0;
    n_irq = 0;
    n_wrap = 0;
    exp_addr = ptr;
    i_host.wr(TDC_PTR_OFS, ptr);
    i_host.wr(TDC_CTL_OFS, ctl);
    i_host.wr(TDC_CMD_OFS, 32'h1);
    k = 0;
    rv = 32'h2;
    while (rv[TDC_ST_BUSY] !== 1'b0 && k < 50) begin
      i_host.rd(TDC_STAT_OFS, rv);
      k++;
    end
    chk(rv[TDC_ST_OWN], 1'b0, "own not returned");
    chk(rv[TDC_ST_BUSY], 1'b0, "still busy");
    chk(hresp, 1'b0, "bus response");
    repeat (4) @(posedge hclk);
  endtask

  task test_single;
    i_host.set_mode(3'h0);
    run(32'hf010_0005, 32'h0000_1003);
    chk(n_rd, 5, "byte count");
    chk(n_done, 1, "frame done");
    chk(n_irq, 1, "irq");
    chk(frame_info, tdc_frame_s'({1'b1, 1'b1, 3'h0, 1'b0, 2'h1}), "info port1");
    i_host.rd(TDC_FRAME_OFS, rv);
    chk(rv[12:8], TDC_IP_HDR_BYTES, "ip header");
    $display("test_single done");
  endtask

  task test_multi;
    i_host.set_mode(3'h0);
    run(32'hd830_0003, 32'h0000_2000);
    chk(n_done + n_irq, 0, "open segment closed");
    run(32'h38f0_0004, 32'h0000_3000);
    chk(n_done, 1, "close");
    chk(n_irq, 0, "irq without flag");
    chk(frame_info, tdc_frame_s'({3'h3, 1'b0, 1'b0, 1'b1, 2'h3}), "bcast");
    i_host.rd(TDC_STAT_OFS, rv);
    chk(rv[31:16], 16'h7, "frame length");
    $display("test_multi done");
  endtask

  task test_zero;
    run(32'h0200_0000, 32'h0000_4000);
    chk(n_rd + n_done, 0, "zero skip");
    chk(n_wrap, 1, "wrap");
    chk(desc_index, 8'h0, "index base");
    $display("test_zero done");
  endtask

  task test_map0;
    i_host.set_mode(3'h1);
    run(32'h6400_0001, 32'h0000_5000);
    chk(frame_info, tdc_frame_s'({2'h1, 1'b0, 3'h6, 2'h0}), "lookup");
    i_host.rd(8'h20, rv);
    chk(rv, 32'h0, "unmapped");
    $display("test_map0 done");
  endtask

  // End segment with no open frame and a sum request with FCS append off: both flags rise, then W1C
  task test_flags;
    i_host.wr(TDC_MODE_OFS, 32'h0);
    run(32'h3000_0001, 32'h0000_6000);
    chk(n_done, 1, "end segment reported");
    i_host.rd(TDC_STAT_OFS, rv);
    chk({rv[TDC_ST_CFGWARN], rv[TDC_ST_SEQERR]}, 2'h3, "flags set");
    i_host.wr(TDC_STAT_OFS, 32'h0000_0018);
    i_host.rd(TDC_STAT_OFS, rv);
    chk({rv[TDC_ST_CFGWARN], rv[TDC_ST_SEQERR]}, 2'h0, "flags cleared");
    $display("test_flags done");
  endtask

  task report_and_stop;
    $display("counts compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Five tests take well under 2000 cycles
  initial begin
    #200000;
    err_count++;
    $display("MISMATCH t=%0t timeout", $time);
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    test_single;
    test_multi;
    test_zero;
    test_map0;
    test_flags;
    report_and_stop;
  end
endmodule // tdc_decode_tb_top
